// file: src/slmrc_consts.svh
// constants of the sleep and reset control block: offsets, fields, resets, timing
// assumes inclusion by bare name from design files that need them
`ifndef SLMRC_CONSTS_SVH
`define SLMRC_CONSTS_SVH

// ==========================================================
// register offsets (byte addresses)
`define SLMRC_CTRL_OFS       8'h00
`define SLMRC_ASYNC_OFS      8'h04
`define SLMRC_STATUS_OFS     8'h08

// ==========================================================
// field positions
`define SLMRC_CTRL_EN_BIT    0
`define SLMRC_CTRL_MODE_LSB  1
`define SLMRC_ASYNC_SEL_BIT  0
`define SLMRC_STAT_PINRST    3
`define SLMRC_STAT_FUNC_LSB  4

// ==========================================================
// reset values
`define SLMRC_CTRL_RST       4'h0
`define SLMRC_ASYNC_RST      1'h0

// ==========================================================
// clock fuse decode and timing
`define SLMRC_CKSEL_RC_LO    4'h1
`define SLMRC_CKSEL_RC_HI    4'h4
`define SLMRC_CKSEL_XTAL_LO  4'h9
`define SLMRC_CLK_PERIOD_NS  4
`define SLMRC_RST_MIN_NS     2500
`define SLMRC_RST_MIN_CYC    ((`SLMRC_RST_MIN_NS + `SLMRC_CLK_PERIOD_NS - 1) / `SLMRC_CLK_PERIOD_NS)

`endif

// file: src/slmrc_pkg.sv
// types shared by the sleep and reset control block
// assumes nothing beyond a systemverilog compiler
package slmrc_pkg;

    // ==========================================================
    // sleep modes as software selects them
    typedef enum logic [2:0] {
        slmrc_mode_idle,
        slmrc_mode_noise,
        slmrc_mode_power_down,
        slmrc_mode_power_save,
        slmrc_mode_standby
    } slmrc_mode_type;

    // sequencer states
    typedef enum logic [1:0] {
        slmrc_st_run,
        slmrc_st_sleep,
        slmrc_st_wake
    } slmrc_state_type;

    // function of the two upper port b pins
    typedef enum logic [1:0] {
        slmrc_pin_gpio,
        slmrc_pin_crystal,
        slmrc_pin_timer_osc
    } slmrc_pinfunc_type;

    // clock enables per domain, 1 = running
    typedef struct packed {
        logic cpu;
        logic io;
        logic spi;
        logic timers;
        logic adc;
        logic async_timer;
        logic osc;
        logic intr;
    } slmrc_gate_type;

endpackage

// file: src/slmrc_port_gate.sv
// forces one port to high impedance while any reset condition holds
// purely combinational so it acts with no clock running
`timescale 1ns/1ps
`default_nettype none
module slmrc_port_gate #(
    parameter int W = 8
) (
    input  wire logic         in_reset,
    input  wire logic [W-1:0] gpio_o,
    input  wire logic [W-1:0] gpio_oe,
    output var  logic [W-1:0] pad_o,
    output var  logic [W-1:0] pad_oe
);
    // ==========================================================
    // no register in the path: reset must reach the pads with the clock stopped
    always_comb begin
        pad_o  = gpio_o;
        pad_oe = in_reset ? '0 : gpio_oe;
    end
endmodule // slmrc_port_gate
`default_nettype wire

// file: src/slmrc_pulse_filter.sv
// qualifies a low level on the reset pin against a minimum length
// assumes pin_low is already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module slmrc_pulse_filter #(
    parameter int MIN_CYC = 625
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin_low,
    output var  logic hold
);
    logic [$clog2(MIN_CYC+1)-1:0] cnt_q;

    // ==========================================================
    // count consecutive low cycles; any high level restarts the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!pin_low) begin
            cnt_q <= '0;
        end else if (cnt_q != ($clog2(MIN_CYC+1))'(MIN_CYC)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // reset stays on while the pin stays low after qualifying
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold <= 1'b0;
        end else begin
            hold <= pin_low && (cnt_q == ($clog2(MIN_CYC+1))'(MIN_CYC));
        end
    end
endmodule // slmrc_pulse_filter
`default_nettype wire

// file: src/slmrc_top.sv
// sleep mode sequencer, reset pin control and port b/c/d tri-state gating
// assumes an ahb-lite master on hclk and synchronous pin inputs
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "slmrc_consts.svh"
module slmrc_top #(
    parameter int RST_MIN_CYC = `SLMRC_RST_MIN_CYC
) (
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // ahb-lite slave
    input  wire logic                        hsel,
    input  wire logic [7:0]                  haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output var  logic [31:0]                 hrdata,
    output var  logic                        hreadyout,
    output var  logic                        hresp,
    // cpu side
    input  wire logic                        sleep_instr,
    input  wire logic                        wake_irq,
    output var  logic                        cpu_reset_n,
    output var  logic                        cpu_resume,
    output var  slmrc_pkg::slmrc_gate_type   clk_gate,
    // fuses
    input  wire logic                        reset_pin_disable_fuse,
    input  wire logic [3:0]                  clock_select_fuses,
    // upper port b pin routing
    output var  slmrc_pkg::slmrc_pinfunc_type osc_pin_func,
    output var  logic                        crystal_in_sel,
    output var  logic                        crystal_out_sel,
    output var  logic                        timer_osc_in_sel,
    output var  logic                        timer_osc_out_sel,
    // port logic outputs before gating
    input  wire logic [7:0]                  port_b_o,
    input  wire logic [7:0]                  port_b_oe,
    input  wire logic [6:0]                  port_c_o,
    input  wire logic [6:0]                  port_c_oe,
    input  wire logic [7:0]                  port_d_o,
    input  wire logic [7:0]                  port_d_oe,
    // pads
    input  wire logic                        shared_reset_pin_i,
    output var  logic [7:0]                  pad_b_o,
    output var  logic [7:0]                  pad_b_oe,
    output var  logic [6:0]                  pad_c_o,
    output var  logic [6:0]                  pad_c_oe,
    output var  logic [7:0]                  pad_d_o,
    output var  logic [7:0]                  pad_d_oe
);
    // ==========================================================
    // declarations
    logic                         sleep_en_q;
    slmrc_pkg::slmrc_mode_type    mode_q;
    logic                         async_sel_q;
    logic                         pin_rst_flag_q;
    slmrc_pkg::slmrc_state_type   state_q;
    slmrc_pkg::slmrc_gate_type    gate_d;
    logic                         dp_write_q;
    logic [7:0]                   dp_addr_q;
    logic                         pin_is_reset;
    logic                         pin_low;
    logic                         pin_hold;
    logic                         in_reset;
    logic                         clk_int_rc;
    logic                         clk_crystal;
    logic                         addr_ok;
    logic                         clr_pinrst;
    logic [6:0]                   port_c_oe_eff;

    // ==========================================================
    // reset pin ownership and qualification
    assign pin_is_reset = !reset_pin_disable_fuse;
    assign pin_low      = pin_is_reset && !shared_reset_pin_i;

    slmrc_pulse_filter #(
        .MIN_CYC (RST_MIN_CYC)
    ) u_rst_filter (
        .clk     (hclk),
        .rst_n   (hresetn),
        .pin_low (pin_low),
        .hold    (pin_hold)
    );

    // raw low level also counts: pads float at once even with no clock
    assign in_reset    = !hresetn || pin_low || pin_hold;
    assign cpu_reset_n = !pin_hold;

    // ==========================================================
    // port tri-state gating, one instance per port
    // pc6 only drives as gpio when the fuse gives it up
    always_comb begin
        port_c_oe_eff    = port_c_oe;
        port_c_oe_eff[6] = port_c_oe[6] && !pin_is_reset;
    end

    slmrc_port_gate #(.W (8)) u_gate_b (
        .in_reset (in_reset),
        .gpio_o   (port_b_o),
        .gpio_oe  (port_b_oe),
        .pad_o    (pad_b_o),
        .pad_oe   (pad_b_oe)
    );

    slmrc_port_gate #(.W (7)) u_gate_c (
        .in_reset (in_reset),
        .gpio_o   (port_c_o),
        .gpio_oe  (port_c_oe_eff),
        .pad_o    (pad_c_o),
        .pad_oe   (pad_c_oe)
    );

    slmrc_port_gate #(.W (8)) u_gate_d (
        .in_reset (in_reset),
        .gpio_o   (port_d_o),
        .gpio_oe  (port_d_oe),
        .pad_o    (pad_d_o),
        .pad_oe   (pad_d_oe)
    );

    // ==========================================================
    // upper port b routing from clock fuses and the select bit
    assign clk_int_rc  = (clock_select_fuses >= `SLMRC_CKSEL_RC_LO) &&
                         (clock_select_fuses <= `SLMRC_CKSEL_RC_HI);
    assign clk_crystal = (clock_select_fuses >= `SLMRC_CKSEL_XTAL_LO);

    // registered so the pad muxes never see fuse decode glitches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_pin_func <= slmrc_pkg::slmrc_pin_gpio;
        end else if (clk_crystal) begin
            osc_pin_func <= slmrc_pkg::slmrc_pin_crystal;
        end else if (clk_int_rc && async_sel_q) begin
            osc_pin_func <= slmrc_pkg::slmrc_pin_timer_osc;
        end else begin
            osc_pin_func <= slmrc_pkg::slmrc_pin_gpio;
        end
    end

    // pb6 is amplifier/timer input, pb7 its output
    always_comb begin
        crystal_in_sel    = (osc_pin_func == slmrc_pkg::slmrc_pin_crystal);
        crystal_out_sel   = crystal_in_sel;
        timer_osc_in_sel  = (osc_pin_func == slmrc_pkg::slmrc_pin_timer_osc);
        timer_osc_out_sel = timer_osc_in_sel;
    end

    // ==========================================================
    // sleep sequencer
    // wake passes one cycle with peripherals back before the cpu restarts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= slmrc_pkg::slmrc_st_run;
        end else if (pin_hold) begin
            state_q <= slmrc_pkg::slmrc_st_run;
        end else begin
            case (state_q)
                slmrc_pkg::slmrc_st_run: begin
                    if (sleep_instr && sleep_en_q) begin
                        state_q <= slmrc_pkg::slmrc_st_sleep;
                    end
                end
                slmrc_pkg::slmrc_st_sleep: begin
                    if (wake_irq) begin
                        state_q <= slmrc_pkg::slmrc_st_wake;
                    end
                end
                slmrc_pkg::slmrc_st_wake: begin
                    state_q <= slmrc_pkg::slmrc_st_run;
                end
                default: begin
                    state_q <= slmrc_pkg::slmrc_st_run;
                end
            endcase
        end
    end

    // gate pattern for the state about to be entered
    always_comb begin
        gate_d = '1;
        case (state_q)
            slmrc_pkg::slmrc_st_run: begin
                if (sleep_instr && sleep_en_q && !pin_hold) begin
                    case (mode_q)
                        slmrc_pkg::slmrc_mode_noise: begin
                            gate_d = '0;
                            gate_d.async_timer = 1'b1;
                            gate_d.adc         = 1'b1;
                            gate_d.osc         = 1'b1;
                            gate_d.intr        = 1'b1;
                        end
                        slmrc_pkg::slmrc_mode_power_down: begin
                            gate_d = '0;
                            gate_d.intr = 1'b1;
                        end
                        slmrc_pkg::slmrc_mode_power_save: begin
                            gate_d = '0;
                            gate_d.async_timer = 1'b1;
                            gate_d.intr        = 1'b1;
                        end
                        slmrc_pkg::slmrc_mode_standby: begin
                            gate_d = '0;
                            gate_d.osc  = 1'b1;
                            gate_d.intr = 1'b1;
                        end
                        default: begin
                            gate_d.cpu = 1'b0;
                        end
                    endcase
                end
            end
            slmrc_pkg::slmrc_st_sleep: begin
                gate_d = clk_gate;
                if (wake_irq) begin
                    gate_d     = '1;
                    gate_d.cpu = 1'b0;
                end
            end
            slmrc_pkg::slmrc_st_wake: begin
                gate_d = '1;
            end
            default: begin
                gate_d = '1;
            end
        endcase
        if (pin_hold) begin
            gate_d = '1;
        end
    end

    // gates come from flip-flops so clock enables never glitch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_gate <= '1;
        end else begin
            clk_gate <= gate_d;
        end
    end

    // one-cycle resume strobe; registers and sram are never touched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_resume <= 1'b0;
        end else begin
            cpu_resume <= (state_q == slmrc_pkg::slmrc_st_wake) && !pin_hold;
        end
    end

    // ==========================================================
    // ahb-lite slave, zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && hready && htrans[1];

    // address phase capture for the write data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_q <= 1'b0;
            dp_addr_q  <= 8'h00;
        end else begin
            dp_write_q <= addr_ok && hwrite;
            dp_addr_q  <= haddr;
        end
    end

    // control register: sleep enable and mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_en_q <= 1'(`SLMRC_CTRL_RST);
            mode_q     <= slmrc_pkg::slmrc_mode_idle;
        end else if (dp_write_q && dp_addr_q == `SLMRC_CTRL_OFS) begin
            sleep_en_q <= hwdata[`SLMRC_CTRL_EN_BIT];
            mode_q     <= slmrc_pkg::slmrc_mode_type'(hwdata[`SLMRC_CTRL_MODE_LSB +: 3]);
        end
    end

    // asynchronous timer clock select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            async_sel_q <= `SLMRC_ASYNC_RST;
        end else if (dp_write_q && dp_addr_q == `SLMRC_ASYNC_OFS) begin
            async_sel_q <= hwdata[`SLMRC_ASYNC_SEL_BIT];
        end
    end

    // pin reset seen flag; write one clears, a new reset wins
    assign clr_pinrst = dp_write_q && dp_addr_q == `SLMRC_STATUS_OFS &&
                        hwdata[`SLMRC_STAT_PINRST];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_rst_flag_q <= 1'b0;
        end else if (pin_hold) begin
            pin_rst_flag_q <= 1'b1;
        end else if (clr_pinrst) begin
            pin_rst_flag_q <= 1'b0;
        end
    end

    // read data registered at the address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= 32'h0000_0000;
            case (haddr)
                `SLMRC_CTRL_OFS: begin
                    hrdata[`SLMRC_CTRL_EN_BIT]          <= sleep_en_q;
                    hrdata[`SLMRC_CTRL_MODE_LSB +: 3]   <= mode_q;
                end
                `SLMRC_ASYNC_OFS: begin
                    hrdata[`SLMRC_ASYNC_SEL_BIT]        <= async_sel_q;
                end
                `SLMRC_STATUS_OFS: begin
                    hrdata[1:0]                         <= state_q;
                    hrdata[`SLMRC_STAT_PINRST]          <= pin_rst_flag_q;
                    hrdata[`SLMRC_STAT_FUNC_LSB +: 2]   <= osc_pin_func;
                end
                default: begin
                    hrdata <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule // slmrc_top
`default_nettype wire

// file: test/slmrc_monitor.sv
// concurrent checks on the ports of the sleep and reset control block
// assumes a bind onto slmrc_top from the bench top file
`timescale 1ns/1ps
`default_nettype none
module slmrc_monitor #(
    parameter int RST_MIN_CYC = 4
) (
    input wire logic                         hclk,
    input wire logic                         hresetn,
    input wire logic                         sleep_instr,
    input wire logic                         wake_irq,
    input wire logic                         cpu_reset_n,
    input wire logic                         cpu_resume,
    input wire slmrc_pkg::slmrc_gate_type    clk_gate,
    input wire logic                         reset_pin_disable_fuse,
    input wire slmrc_pkg::slmrc_pinfunc_type osc_pin_func,
    input wire logic                         crystal_in_sel,
    input wire logic                         timer_osc_in_sel,
    input wire logic                         shared_reset_pin_i,
    input wire logic [7:0]                   pad_b_oe,
    input wire logic [6:0]                   pad_c_oe,
    input wire logic [7:0]                   pad_d_oe
);
    // ====================================
    // helper: consecutive low samples of the reset pin
    logic        pin_rst;
    logic [15:0] low_q;
    assign pin_rst = !reset_pin_disable_fuse && !shared_reset_pin_i;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_q <= 16'h0000;
        end else if (pin_rst) begin
            low_q <= low_q + 16'h0001;
        end else begin
            low_q <= 16'h0000;
        end
    end

    // ====================================
    // properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_wake_go;
        !clk_gate.cpu && wake_irq && !$past(wake_irq);
    endsequence
    sequence s_wake_steps;
        clk_gate == 8'h7f ##1 clk_gate == 8'hff && cpu_resume ##1 !cpu_resume;
    endsequence
    // no disable: pads float in block reset too
    property p_pad_float;
        disable iff (1'b0) (!hresetn || pin_rst) |->
            (pad_b_oe == 8'h00 && pad_c_oe == 7'h00 && pad_d_oe == 8'h00);
    endproperty
    property p_pin_gpio;
        reset_pin_disable_fuse |-> cpu_reset_n;
    endproperty
    property p_pin_long;
        low_q >= 16'(RST_MIN_CYC + 2) |-> !cpu_reset_n;
    endproperty
    property p_pin_short;
        $fell(cpu_reset_n) |-> low_q >= 16'(RST_MIN_CYC);
    endproperty
    property p_pin_free;
        (!cpu_reset_n && shared_reset_pin_i) |-> ##[1:3] cpu_reset_n;
    endproperty
    property p_sleep_cause;
        $fell(clk_gate.cpu) |-> $past(sleep_instr);
    endproperty
    property p_gate_set;
        !clk_gate.cpu |-> clk_gate inside {8'h7f, 8'h0f, 8'h01, 8'h05, 8'h03};
    endproperty
    property p_sleep_hold;
        (!clk_gate.cpu && !wake_irq && !$past(wake_irq) && cpu_reset_n) |=> $stable(clk_gate);
    endproperty
    property p_wake;
        s_wake_go |=> s_wake_steps;
    endproperty
    property p_route_timer;
        osc_pin_func == slmrc_pkg::slmrc_pin_timer_osc |-> timer_osc_in_sel && !crystal_in_sel;
    endproperty
    property p_route_xtal;
        osc_pin_func == slmrc_pkg::slmrc_pin_crystal |-> crystal_in_sel && !timer_osc_in_sel;
    endproperty

    a_pad_float: assert property (p_pad_float)
        else $error("port driven during reset");
    a_pin_gpio: assert property (p_pin_gpio)
        else $error("gpio pin caused reset");
    a_pin_long: assert property (p_pin_long)
        else $error("long low pulse gave no reset");
    a_pin_short: assert property (p_pin_short)
        else $error("reset before minimum pulse");
    a_pin_free: assert property (p_pin_free)
        else $error("reset not released");
    a_sleep_cause: assert property (p_sleep_cause)
        else $error("cpu stopped without sleep");
    a_gate_set: assert property (p_gate_set)
        else $error("illegal gate set in sleep");
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("gates moved without wake");
    a_wake: assert property (p_wake)
        else $error("wake steps wrong");
    a_route_timer: assert property (p_route_timer)
        else $error("timer osc pins not routed");
    a_route_xtal: assert property (p_route_xtal)
        else $error("crystal pins not routed");
endmodule // slmrc_monitor
`default_nettype wire

// file: test/tb.sv
// self-checking bench of the sleep and reset control block
// assumes slmrc_pkg, slmrc_top and slmrc_monitor compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %0h want %0h", $time, got, exp); end end
module tb;
    localparam int RST = 4; // short pulse filter keeps the run brief
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd, r;
    logic hreadyout, hresp, cpu_reset_n, cpu_resume, crystal_in_sel, crystal_out_sel;
    logic sleep_instr = 1'b0, wake_irq = 1'b0, timer_osc_in_sel, timer_osc_out_sel;
    logic reset_pin_disable_fuse = 1'b0, shared_reset_pin_i = 1'b1;
    logic [3:0] clock_select_fuses = 4'h0;
    logic [1:0] fx;
    slmrc_pkg::slmrc_gate_type clk_gate;
    slmrc_pkg::slmrc_pinfunc_type osc_pin_func;
    logic [7:0] port_b_o, port_b_oe, port_d_o, port_d_oe, pad_b_o, pad_b_oe, pad_d_o, pad_d_oe;
    logic [6:0] port_c_o, port_c_oe, pad_c_o, pad_c_oe;
    logic [31:0] seed = 32'h3d375ac5;
    int mismatches = 0, tests_run = 0, cycles = 0;

    slmrc_top #(.RST_MIN_CYC(RST)) dut (.*);

    // ====================================
    // clock, bus ready and hang guard
    always #2 hclk = ~hclk;
    assign hready = hreadyout; // single slave drives the bus ready
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end

    // ====================================
    // helpers and expectations
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] gate_of(input logic [2:0] m);
        case (m) // unused codes fall back to idle
            3'h1: return 8'h0f;
            3'h2: return 8'h01;
            3'h3: return 8'h05;
            3'h4: return 8'h03;
            default: return 8'h7f;
        endcase
    endfunction
    function automatic logic [1:0] func_of(input logic [3:0] f, input logic s);
        if (f >= 4'h9) return 2'h1; // crystal fuses win over the select bit
        if (f >= 4'h1 && f <= 4'h4 && s) return 2'h2;
        return 2'h0;
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // single transfer, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        `CHK(hresp, 1'b0) // slave answers okay only
    endtask
    task automatic new_ports();
        r = rnd();
        {port_b_o, port_b_oe, port_d_o, port_d_oe} <= r;
        r = rnd();
        {port_c_o, port_c_oe} <= r[13:0];
    endtask
    task automatic pads(input logic fl);
        `CHK(pad_b_oe, fl ? 8'h00 : port_b_oe)
        `CHK(pad_c_oe, fl ? 7'h00 : port_c_oe & {reset_pin_disable_fuse, 6'h3f})
        `CHK(pad_d_oe, fl ? 8'h00 : port_d_oe)
        if (!fl) `CHK({pad_b_o, pad_c_o, pad_d_o}, {port_b_o, port_c_o, port_d_o})
    endtask
    // sleep and wake in mode m; sleep refused when en is low
    task automatic nap(input logic [2:0] m, input logic en);
        bus(1'b1, 8'h00, {28'h0, m, en});
        sleep_instr <= 1'b1;
        @(posedge hclk);
        sleep_instr <= 1'b0;
        @(negedge hclk);
        `CHK(clk_gate, en ? gate_of(m) : 8'hff)
        if (en) begin
            @(posedge hclk);
            bus(1'b0, 8'h08, 32'h0);
            `CHK(rd[1:0], 2'h1)
            repeat (rnd() % 8) @(posedge hclk);
            wake_irq <= 1'b1;
            @(posedge hclk);
            wake_irq <= 1'b0;
            @(negedge hclk);
            `CHK(clk_gate, 8'h7f)
            @(negedge hclk);
            `CHK(clk_gate, 8'hff)
            `CHK(cpu_resume, 1'b1)
            @(negedge hclk);
            `CHK(cpu_resume, 1'b0)
        end
        @(posedge hclk);
    endtask

    // ====================================
    // main sequence
    initial begin
        new_ports();
        repeat (12) @(posedge hclk);
        pads(1'b1);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, 8'h0c, rnd()); // unmapped word
        bus(1'b0, 8'h0c, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, 8'h08, 32'h37); // status ignores writes except a one in bit 3, which clears the flag
        bus(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h0)
        r = rnd();
        bus(1'b1, 8'h00, r);
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, {28'h0, r[3:0]})
        nap(3'h0, 1'b0);
        for (int m = 0; m < 8; m++) nap(3'(m), 1'b1);
        repeat (4) nap(3'(rnd()), 1'b1);
        for (int i = 0; i < 32; i++) begin
            bus(1'b1, 8'h04, {31'h0, i[4]});
            clock_select_fuses <= 4'(i);
            repeat (3) @(posedge hclk);
            bus(1'b0, 8'h08, 32'h0);
            fx = func_of(4'(i), i[4]);
            `CHK(osc_pin_func, fx)
            `CHK(rd[5:4], fx)
            `CHK({crystal_in_sel, crystal_out_sel, timer_osc_in_sel, timer_osc_out_sel},
                {fx == 2'h1, fx == 2'h1, fx == 2'h2, fx == 2'h2})
        end
        clock_select_fuses <= 4'h0;
        new_ports();
        shared_reset_pin_i <= 1'b0;
        #1 pads(1'b1);
        repeat (RST + 3) @(posedge hclk);
        @(negedge hclk);
        `CHK(cpu_reset_n, 1'b0)
        @(posedge hclk);
        shared_reset_pin_i <= 1'b1;
        repeat (3) @(negedge hclk);
        `CHK(cpu_reset_n, 1'b1)
        pads(1'b0);
        @(posedge hclk);
        bus(1'b0, 8'h08, 32'h0);
        `CHK(rd[3], 1'b1)
        bus(1'b1, 8'h08, 32'h8);
        bus(1'b0, 8'h08, 32'h0);
        `CHK(rd[3], 1'b0)
        reset_pin_disable_fuse <= 1'b1;
        shared_reset_pin_i <= 1'b0;
        repeat (RST + 3) @(negedge hclk);
        `CHK(cpu_reset_n, 1'b1)
        pads(1'b0);
        @(posedge hclk);
        shared_reset_pin_i <= 1'b1;
        reset_pin_disable_fuse <= 1'b0;
        bus(1'b1, 8'h00, 32'h5); // power-down, then block reset mid-sleep
        sleep_instr <= 1'b1;
        @(posedge hclk);
        sleep_instr <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        `CHK(clk_gate, 8'hff)
        pads(1'b1);
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0)
        conclude();
    end
endmodule // tb

bind slmrc_top slmrc_monitor #(.RST_MIN_CYC(RST_MIN_CYC)) u_mon (.hclk, .hresetn,
    .sleep_instr, .wake_irq, .cpu_reset_n, .cpu_resume, .clk_gate, .reset_pin_disable_fuse,
    .osc_pin_func, .crystal_in_sel, .timer_osc_in_sel, .shared_reset_pin_i, .pad_b_oe,
    .pad_c_oe, .pad_d_oe);
`default_nettype wire
